// File: hdl/twc_top.sv
// Temperature window comparator core with two-wire slave link
// Operation
// - Window alarm outside low/high band, critical alarm above critical; mode and polarity set.
// - High and critical flags clear only below limit minus hysteresis.
// - Low flag sets below low limit, clears above low plus hysteresis.
// - Reads and other accesses never change the status flags.
// - Critical alarm follows the critical flag in every mode.
// - Reads leave the critical alarm alone but restart conversion.
// - Comparator mode: a read releases the window alarm until next conversion.
// - Comparator mode: conversion end reasserts window alarm if condition still holds.
// - Comparator mode without reads: alarm follows the flag condition.
// - Event mode: alarm set once per event, cleared by read until next event.
// - Event mode without reads: alarm stays set after first event.
// - Event is a change of high or low flag: a limit crossed outward, or its hysteresis point crossed back afterward.
// - Event mode: after read, low alarm returns only on rise above low plus hysteresis.
// - Any register read restarts the conversion.
// - Power-up: comparator mode, active low, default limits, pointer on temperature.
// - Slave only: serial clock is an input, data line is two-way.
// - Slave address is fixed 10010 plus two address select pins.
// - Temperature and limits are 13-bit two's complement, 0.0625 degree step.
// - Temperature readable anytime; fast repeated reads stall updates.
// - Limits read and write; temperature is read only.
// - Temperature word holds value in 15:3, crit/high/low flags in 2:0.
// - Mode bit: 0 comparator, 1 event.
// - Polarity bits per alarm: 0 active low, 1 active high.
// - Fault queue on: four consecutive out-of-limit results before flags set.
`timescale 1ns/1ps
`include "twc_defs.svh"
`default_nettype none

module twc_top
   import twc_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output var  logic        o_sda,
   output var  logic        o_sda_oe_n,
   input  wire logic        i_addr_select_low,
   input  wire logic        i_addr_select_high,
   input  wire logic [12:0] i_adc_temp,
   output var  logic        o_window_alarm_oe_n,
   output var  logic        o_critical_alarm_out_oe_n
);

   //------------------------------------------------------------------
   // Link domain, clocked by the serial clock
   //------------------------------------------------------------------
   twc_link_t  l_q;
   twc_link_t  l_d;
   twc_core_t  c_q;
   twc_core_t  c_d;
   logic       start_tog;
   logic       sda_rise_q;
   logic [7:0] rx_byte;
   logic [7:0] next_tx;

   // Start marker: data falls while clock high; a toggle survives a stopped clock
   always_ff @(negedge i_sda or posedge i_rst) begin
      if (i_rst) begin
         start_tog <= 1'b0;
      end else if (i_scl) begin
         start_tog <= ~start_tog;
      end
   end

   // Data is sampled on the rising clock edge, acted on at the falling one
   always_ff @(posedge i_scl or posedge i_rst) begin
      if (i_rst) begin
         sda_rise_q <= 1'b1;
      end else begin
         sda_rise_q <= i_sda;
      end
   end

   assign rx_byte = {l_q.sh[6:0], sda_rise_q};
   assign next_tx = l_q.byte_idx[0] ? l_q.tx_word[15:8] : l_q.tx_word[7:0];

   // Link protocol; data changes only while the clock is low
   always_comb begin
      l_d        = l_q;
      l_d.adr_s1 = {i_addr_select_high, i_addr_select_low};
      l_d.adr_s2 = l_q.adr_s1;
      l_d.pub_s1 = c_q.pub_tog;
      l_d.pub_s2 = l_q.pub_s1;
      // Take the newest read word the core has published
      if (l_q.pub_s2 != l_q.ack_tog) begin
         l_d.tx_word = c_q.pub_data;
         l_d.ack_tog = l_q.pub_s2;
      end
      if (start_tog != l_q.start_seen) begin
         l_d.start_seen = start_tog;
         l_d.st         = TWC_ADDR;
         l_d.bit_cnt    = 3'h0;
         l_d.byte_idx   = 2'h0;
         l_d.sda_oe_n   = 1'b1;
      end else begin
         case (l_q.st)
            TWC_ADDR: begin
               l_d.sh      = rx_byte;
               l_d.bit_cnt = l_q.bit_cnt + 3'h1;
               if (l_q.bit_cnt == 3'h7) begin
                  if (rx_byte[7:1] == {`TWC_ADDR_FIXED, l_q.adr_s2}) begin
                     l_d.sda_oe_n = 1'b0;
                     l_d.is_read  = rx_byte[0];
                     l_d.st       = TWC_ACK_ADDR;
                     if (rx_byte[0]) begin
                        l_d.rd_tog = ~l_q.rd_tog;
                     end
                  end else begin
                     l_d.st = TWC_IDLE;
                  end
               end
            end
            TWC_ACK_ADDR: begin
               l_d.bit_cnt = 3'h0;
               l_d.sda_oe_n = 1'b1;
               l_d.st       = TWC_RX;
               if (l_q.is_read) begin
                  // High byte first, most significant bit first
                  l_d.sda_oe_n = l_q.tx_word[15];
                  l_d.tx_sh    = {l_q.tx_word[14:8], 1'b0};
                  l_d.bit_cnt  = 3'h1;
                  l_d.byte_idx = 2'h0;
                  l_d.st       = TWC_TX;
               end
            end
            TWC_TX: begin
               l_d.bit_cnt = l_q.bit_cnt + 3'h1;
               if (l_q.bit_cnt == 3'h0) begin
                  l_d.sda_oe_n = 1'b1;
                  l_d.st       = TWC_ACK_TX;
               end else begin
                  l_d.sda_oe_n = l_q.tx_sh[7];
                  l_d.tx_sh    = {l_q.tx_sh[6:0], 1'b0};
               end
            end
            TWC_ACK_TX: begin
               if (!sda_rise_q) begin
                  l_d.byte_idx = {1'b0, ~l_q.byte_idx[0]};
                  l_d.sda_oe_n = next_tx[7];
                  l_d.tx_sh    = {next_tx[6:0], 1'b0};
                  l_d.bit_cnt  = 3'h1;
                  l_d.st       = TWC_TX;
               end else begin
                  // Master declined further bytes
                  l_d.st = TWC_IDLE;
               end
            end
            TWC_RX: begin
               l_d.sh      = rx_byte;
               l_d.bit_cnt = l_q.bit_cnt + 3'h1;
               if (l_q.bit_cnt == 3'h7) begin
                  l_d.sda_oe_n = 1'b0;
                  l_d.st       = TWC_ACK_RX;
                  if (l_q.byte_idx != 2'h3) begin
                     l_d.byte_idx = l_q.byte_idx + 2'h1;
                  end
                  case (l_q.byte_idx)
                     2'h0: begin
                        l_d.ptr_rx     = rx_byte[2:0];
                        l_d.wr.is_data = 1'b0;
                        l_d.wr.data    = {8'h00, rx_byte};
                        l_d.wr_tog     = ~l_q.wr_tog;
                     end
                     2'h1: begin
                        l_d.wr.is_data    = 1'b1;
                        l_d.wr.data[15:8] = rx_byte;
                        if (l_q.ptr_rx == `TWC_PTR_CFG) begin
                           l_d.wr_tog = ~l_q.wr_tog;
                        end
                     end
                     2'h2: begin
                        l_d.wr.data[7:0] = rx_byte;
                        if (l_q.ptr_rx != `TWC_PTR_CFG) begin
                           l_d.wr_tog = ~l_q.wr_tog;
                        end
                     end
                     default: l_d.wr_tog = l_q.wr_tog;
                  endcase
               end
            end
            TWC_ACK_RX: begin
               l_d.sda_oe_n = 1'b1;
               l_d.bit_cnt  = 3'h0;
               l_d.st       = TWC_RX;
            end
            default: begin
               l_d.st       = TWC_IDLE;
               l_d.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   // Serial clock may stop at rest, so the link resets without it
   always_ff @(negedge i_scl or posedge i_rst) begin
      if (i_rst) begin
         l_q <= '{st: TWC_IDLE, sda_oe_n: 1'b1, default: '0};
      end else begin
         l_q <= l_d;
      end
   end

   assign o_sda      = l_q.sda_o;
   assign o_sda_oe_n = l_q.sda_oe_n;

   //------------------------------------------------------------------
   // Core domain: conversion timing, comparison and alarms
   //------------------------------------------------------------------
   logic              wr_evt;
   logic              rd_evt;
   logic              done;
   logic              int_act;
   logic [2:0]        trip;
   logic [2:0]        rel;
   logic [15:0]       rd_word;
   logic [2:0][12:0]  lim_of;
   logic signed [13:0] t_s;
   logic signed [13:0] h_s;
   logic signed [13:0] l_s;

   assign wr_evt = c_q.wr_s[2] ^ c_q.wr_s[1];
   assign rd_evt = c_q.rd_s[2] ^ c_q.rd_s[1];
   // A read in the last cycle aborts the conversion instead of finishing it
   assign done   = (c_q.conv == 11'(`TWC_CONV_CYCLES - 1)) && !rd_evt;

   // Limit seen by each flag and its trip and release tests
   always_comb begin
      lim_of[`TWC_FLG_LOW]  = c_q.lim[`TWC_LIM_LOW];
      lim_of[`TWC_FLG_HIGH] = c_q.lim[`TWC_LIM_HIGH];
      lim_of[`TWC_FLG_CRIT] = c_q.lim[`TWC_LIM_CRIT];
      t_s = signed'({i_adc_temp[12], i_adc_temp});
      h_s = signed'({c_q.lim[`TWC_LIM_HYST][12], c_q.lim[`TWC_LIM_HYST]});
      l_s = '0;
      for (int i = 0; i < 3; i++) begin
         l_s = signed'({lim_of[i][12], lim_of[i]});
         if (i == `TWC_FLG_LOW) begin
            trip[i] = t_s < l_s;
            rel[i]  = t_s > (l_s + h_s);
         end else begin
            trip[i] = t_s > l_s;
            rel[i]  = t_s < (l_s - h_s);
         end
      end
   end

   // Word returned for the selected register
   always_comb begin
      case (c_q.ptr)
         `TWC_PTR_TEMP: rd_word = {c_q.temp, c_q.flags};
         `TWC_PTR_CFG:  rd_word = {3'h0, c_q.cfg, 8'h00};
         3'h2, 3'h3, 3'h4, 3'h5:
            rd_word = {c_q.lim[2'(c_q.ptr - `TWC_PTR_LIM_BASE)], 3'h0};
         default:       rd_word = 16'h0000;
      endcase
   end

   // Core next state
   always_comb begin
      c_d       = c_q;
      c_d.wr_s  = {c_q.wr_s[1:0], l_q.wr_tog};
      c_d.rd_s  = {c_q.rd_s[1:0], l_q.rd_tog};
      c_d.ack_s = {c_q.ack_s[0], l_q.ack_tog};
      // Write item is stable while its toggle crosses over
      if (wr_evt) begin
         if (!l_q.wr.is_data) begin
            c_d.ptr = l_q.wr.data[2:0];
         end else if (c_q.ptr == `TWC_PTR_CFG) begin
            c_d.cfg = l_q.wr.data[12:8];
         end else if (c_q.ptr >= `TWC_PTR_LIM_BASE && c_q.ptr <= `TWC_PTR_LAST) begin
            c_d.lim[2'(c_q.ptr - `TWC_PTR_LIM_BASE)] = l_q.wr.data[15:3];
         end
      end
      // Free-running conversion, restarted by any read
      c_d.conv = (rd_evt || done) ? 11'h000 : c_q.conv + 11'h001;
      if (rd_evt) begin
         c_d.blank = 1'b1;
         c_d.evt   = 1'b0;
      end
      if (done) begin
         c_d.temp  = i_adc_temp;
         c_d.blank = 1'b0;
         for (int i = 0; i < 3; i++) begin
            if (!trip[i]) begin
               c_d.fq[i] = 3'h0;
            end else if (c_q.fq[i] != `TWC_FQ_DEPTH) begin
               c_d.fq[i] = c_q.fq[i] + 3'h1;
            end
            if (!c_q.flags[i] && trip[i] &&
                (!c_q.cfg[`TWC_CFG_FQ] || c_d.fq[i] == `TWC_FQ_DEPTH)) begin
               c_d.flags[i] = 1'b1;
            end else if (c_q.flags[i] && rel[i]) begin
               c_d.flags[i] = 1'b0;
            end
         end
         // Any change of low or high flag is a window event
         if ((c_d.flags[`TWC_FLG_LOW] != c_q.flags[`TWC_FLG_LOW]) ||
             (c_d.flags[`TWC_FLG_HIGH] != c_q.flags[`TWC_FLG_HIGH])) begin
            c_d.evt = 1'b1;
         end
      end
      // Window alarm: event latch, or flag level masked after a read
      if (c_d.cfg[`TWC_CFG_MODE]) begin
         int_act = c_d.evt;
      end else begin
         int_act = (c_d.flags[`TWC_FLG_LOW] | c_d.flags[`TWC_FLG_HIGH]) & ~c_d.blank;
      end
      c_d.int_oe_n  = c_d.cfg[`TWC_CFG_INT_POL] ? int_act : ~int_act;
      c_d.crit_oe_n = c_d.cfg[`TWC_CFG_CRIT_POL] ? c_d.flags[`TWC_FLG_CRIT]
                                                 : ~c_d.flags[`TWC_FLG_CRIT];
      // Publish a fresh read word once the link took the last one
      if (c_q.pub_tog == c_q.ack_s[1]) begin
         c_d.pub_data = rd_word;
         c_d.pub_tog  = ~c_q.pub_tog;
      end
   end

   // Core state register with power-up values
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         c_q <= '{lim: '{`TWC_DEF_HIGH, `TWC_DEF_LOW, `TWC_DEF_CRIT, `TWC_DEF_HYST},
                  ptr: `TWC_PTR_TEMP, int_oe_n: 1'b1, crit_oe_n: 1'b1,
                  default: '0};
      end else begin
         c_q <= c_d;
      end
   end

   assign o_window_alarm_oe_n       = c_q.int_oe_n;
   assign o_critical_alarm_out_oe_n = c_q.crit_oe_n;

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   logic int_on;
   logic crit_on;
   assign int_on  = c_q.cfg[`TWC_CFG_INT_POL] ? c_q.int_oe_n : ~c_q.int_oe_n;
   assign crit_on = c_q.cfg[`TWC_CFG_CRIT_POL] ? c_q.crit_oe_n : ~c_q.crit_oe_n;

   crit_follow_a: assert property (@(posedge i_clock) disable iff (i_rst)
      crit_on == c_q.flags[`TWC_FLG_CRIT]) else $error("critical alarm off its flag");
   read_restart_a: assert property (@(posedge i_clock) disable iff (i_rst)
      rd_evt |=> (c_q.conv == 11'h000) ##1 (c_q.conv == 11'h001)) else $error("no restart");
   comp_blank_a: assert property (@(posedge i_clock) disable iff (i_rst)
      rd_evt && !c_d.cfg[`TWC_CFG_MODE] |=> !int_on) else $error("read did not release");
   comp_return_a: assert property (@(posedge i_clock) disable iff (i_rst)
      done && !c_d.cfg[`TWC_CFG_MODE] && (c_d.flags[1] || c_d.flags[0]) |=> int_on)
      else $error("alarm not reasserted");
   evt_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      c_q.cfg[`TWC_CFG_MODE] && int_on && !rd_evt && !wr_evt |=> int_on)
      else $error("event alarm dropped");
   evt_cause_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(c_q.evt) |-> $past(done) && ($past(c_q.flags[1:0]) != c_q.flags[1:0]))
      else $error("event without crossing");
   flags_steady_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !done |=> $stable(c_q.flags)) else $error("flags moved off conversion end");
   high_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      done && c_q.flags[`TWC_FLG_HIGH] && !rel[`TWC_FLG_HIGH] |=> c_q.flags[`TWC_FLG_HIGH])
      else $error("high flag cleared inside hysteresis");
   queue_wait_a: assert property (@(posedge i_clock) disable iff (i_rst)
      done && c_q.cfg[`TWC_CFG_FQ] && !c_q.flags[2] && c_q.fq[2] < 3'h3 |=> !c_q.flags[2])
      else $error("fault queue bypassed");

endmodule : twc_top

`default_nettype wire

// File: hdl/twc_defs.svh
// Constants for the temperature window comparator
`ifndef TWC_DEFS_SVH
`define TWC_DEFS_SVH

// Core clock and conversion timing
`define TWC_CLK_MHZ        20
`define TWC_CONV_TIME_US   100
`define TWC_CONV_CYCLES    (`TWC_CONV_TIME_US * `TWC_CLK_MHZ)

// Fixed upper part of the slave address
`define TWC_ADDR_FIXED     5'h12

// Register select codes
`define TWC_PTR_TEMP       3'h0
`define TWC_PTR_CFG        3'h1
`define TWC_PTR_LIM_BASE   3'h2
`define TWC_PTR_LAST       3'h5

// Limit bank slots
`define TWC_LIM_HYST       0
`define TWC_LIM_CRIT       1
`define TWC_LIM_LOW        2
`define TWC_LIM_HIGH       3

// Power-up limit values, 0.0625 degree steps
`define TWC_DEF_HYST       13'h0020
`define TWC_DEF_CRIT       13'h0500
`define TWC_DEF_LOW        13'h00A0
`define TWC_DEF_HIGH       13'h0400

// Configuration bit positions
`define TWC_CFG_SHDN       0
`define TWC_CFG_MODE       1
`define TWC_CFG_CRIT_POL   2
`define TWC_CFG_INT_POL    3
`define TWC_CFG_FQ         4

// Status flag positions and fault queue depth
`define TWC_FLG_LOW        0
`define TWC_FLG_HIGH       1
`define TWC_FLG_CRIT       2
`define TWC_FQ_DEPTH       3'h4

`endif

// File: hdl/twc_pkg.sv
// Types shared by the temperature window comparator
`default_nettype none

package twc_pkg;

   // Serial link states
   typedef enum logic [2:0] {
      TWC_IDLE     = 3'b000,
      TWC_ADDR     = 3'b001,
      TWC_ACK_ADDR = 3'b010,
      TWC_RX       = 3'b011,
      TWC_ACK_RX   = 3'b100,
      TWC_TX       = 3'b101,
      TWC_ACK_TX   = 3'b110
   } twc_link_state_t;

   // Write item handed from the link to the core
   typedef struct packed {
      logic        is_data;
      logic [15:0] data;
   } twc_wr_msg_t;

   // Link domain state
   typedef struct packed {
      twc_link_state_t st;
      logic [2:0]      bit_cnt;
      logic [7:0]      sh;
      logic [7:0]      tx_sh;
      logic [1:0]      byte_idx;
      logic [2:0]      ptr_rx;
      logic            is_read;
      logic [15:0]     tx_word;
      logic            sda_o;
      logic            sda_oe_n;
      logic            start_seen;
      logic            rd_tog;
      logic            wr_tog;
      twc_wr_msg_t     wr;
      logic            pub_s1;
      logic            pub_s2;
      logic            ack_tog;
      logic [1:0]      adr_s1;
      logic [1:0]      adr_s2;
   } twc_link_t;

   // Core domain state
   typedef struct packed {
      logic [2:0]            wr_s;
      logic [2:0]            rd_s;
      logic [1:0]            ack_s;
      logic [2:0]            ptr;
      logic [4:0]            cfg;
      logic [3:0][12:0]      lim;
      logic [12:0]           temp;
      logic [2:0]            flags;
      logic [2:0][2:0]       fq;
      logic [10:0]           conv;
      logic                  blank;
      logic                  evt;
      logic                  int_oe_n;
      logic                  crit_oe_n;
      logic                  pub_tog;
      logic [15:0]           pub_data;
   } twc_core_t;

endpackage : twc_pkg

`default_nettype wire

// File: tb/twc_host.sv
// Two-wire bus master model for the comparator's serial link
`timescale 1ns/1ps
`default_nettype none

module twc_host (
   output var  logic o_scl,
   output var  logic o_sda_oe_n,
   input  wire logic i_sda
);
   // --------------------
   // Bus phases
   // --------------------
   localparam int Q = 20;  // Quarter of the 80 ns bus clock

   // Clock idles high, data released between frames
   initial begin
      o_scl      = 1'h1;
      o_sda_oe_n = 1'h1;
   end

   // Start or repeated start; odd offset keeps edges off the core clock
   task automatic start();
      #7;
      o_sda_oe_n = 1'h1;
      #Q o_scl = 1'h1;
      #Q o_sda_oe_n = 1'h0;
      #Q o_scl = 1'h0;
      #Q;
   endtask : start

   // Stop, leaving the bus idle
   task automatic stop();
      o_sda_oe_n = 1'h0;
      #Q o_scl = 1'h1;
      #Q o_sda_oe_n = 1'h1;
      #Q;
   endtask : stop

   // One bit: data moves in the low phase, sampled in the high phase
   task automatic bit_io(input logic b, output logic s);
      o_sda_oe_n = b;
      #Q o_scl = 1'h1;
      #Q s = i_sda;
      #Q o_scl = 1'h0;
      #Q;
   endtask : bit_io

   // Byte plus acknowledge slot; send 8'hFF to read
   task automatic xbyte(input logic [7:0] tx, input logic ak_in,
                        output logic [7:0] rx, output logic ak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(ak_in, ak);
   endtask : xbyte
endmodule : twc_host

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the temperature window comparator
`timescale 1ns/1ps
`include "twc_defs.svh"
`default_nettype none

// Counted comparison, mismatch reported at once
`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
      end \
   end

module testbench;
   // --------------------
   // Design and bus master
   // --------------------
   localparam logic [6:0]       ADDR = 7'h49;  // 10010 plus straps 0 and 1
   localparam int               CONV = `TWC_CONV_CYCLES + 100;
   localparam logic [3:0][12:0] DEFS = {`TWC_DEF_HIGH, `TWC_DEF_LOW,
                                        `TWC_DEF_CRIT, `TWC_DEF_HYST};
   logic        clock      = 1'h0;
   logic        rst        = 1'h1;
   logic [12:0] adc        = 13'h0190;
   logic [1:0]  strap      = 2'h1;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          cycles     = 0;
   logic        scl, host_oe_n, dut_sda, dut_oe_n, win_n, crit_n;
   // Pulled-up data line; whoever pulls low wins
   wire logic   sda_line = host_oe_n & (dut_oe_n ? 1'h1 : dut_sda);

   twc_top DUT (
      .i_clock                   (clock),
      .i_rst                     (rst),
      .i_scl                     (scl),
      .i_sda                     (sda_line),
      .o_sda                     (dut_sda),
      .o_sda_oe_n                (dut_oe_n),
      .i_addr_select_low         (strap[0]),
      .i_addr_select_high        (strap[1]),
      .i_adc_temp                (adc),
      .o_window_alarm_oe_n       (win_n),
      .o_critical_alarm_out_oe_n (crit_n)
   );
   twc_host host (
      .o_scl      (scl),
      .o_sda_oe_n (host_oe_n),
      .i_sda      (sda_line)
   );

   // 50 ns clock; the run needs about 60k cycles, so cut it off at 70k
   always #25 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 70000) begin
         fail_count++;
         results();
      end
   end

   task automatic results();
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc

   // Enough cycles for at least one conversion end
   task automatic conv();
      cyc(CONV);
   endtask : conv

   task automatic set(input logic [12:0] t);
      @(posedge clock);
      adc <= t;
   endtask : set

   // Alarm enables looked at away from the launching edge
   task automatic pins(input logic w, input logic c);
      @(negedge clock);
      `CHK("window", w, win_n)
      `CHK("critical", c, crit_n)
   endtask : pins

   // Address, pointer, nw data bytes, then repeated start and nr bytes read
   task automatic acc(input logic [6:0] a, input logic [2:0] p, input int nw,
                      input logic [15:0] wd, input int nr,
                      output logic [15:0] rd, output logic nak);
      logic [7:0] b;
      logic       k;
      rd = 16'h0000;
      host.start();
      host.xbyte({a, 1'h0}, 1'h1, b, nak);
      host.xbyte({5'h00, p}, 1'h1, b, k);
      if (nw == 2)
         host.xbyte(wd[15:8], 1'h1, b, k);
      if (nw > 0)
         host.xbyte(wd[7:0], 1'h1, b, k);
      if (nr > 0) begin
         #400;  // Core needs time to publish the new pointer
         host.start();
         host.xbyte({a, 1'h1}, 1'h1, b, k);
         for (int i = 0; i < nr; i++) begin
            host.xbyte(8'hFF, (i == nr - 1), b, k);
            rd = {rd[7:0], b};
         end
      end
      host.stop();
   endtask : acc

   task automatic rw(input logic [2:0] p, input int nw, input logic [15:0] wd,
                     input int nr, input logic [15:0] e, input string nm);
      logic [15:0] rd;
      logic        nak;
      acc(ADDR, p, nw, wd, nr, rd, nak);
      if (p >= 3'h2)
         rd[2:0] = 3'h0;  // Low bits of limits read as zero
      `CHK(nm, e, rd)
   endtask : rw

   // --------------------
   // Test sequence
   // --------------------
   initial begin
      logic [15:0] rd;
      logic        nak;
      cyc(12);
      rst <= 1'h0;
      cyc(4);
      pins(1'h1, 1'h1);
      conv();
      pins(1'h1, 1'h1);
      rw(3'h0, 0, 16'h0000, 2, 16'h0C80, "temp");
      rw(3'h1, 0, 16'h0000, 1, 16'h0000, "config");
      for (int p = 2; p <= 5; p++)
         rw(3'(p), 0, 16'h0000, 2, {DEFS[p - 2], 3'h0}, "limit");
      rw(3'h0, 2, 16'hFFF8, 2, 16'h0C80, "temp write");
      rw(3'h5, 2, 16'h1800, 2, 16'h1800, "high");
      acc(7'h4A, 3'h0, 0, 16'h0000, 0, rd, nak);
      `CHK("foreign address", 1'h1, nak)
      acc(ADDR, 3'h0, 0, 16'h0000, 0, rd, nak);
      `CHK("own address", 1'h0, nak)
      // Swapped straps move the address between frames
      cyc(1);
      strap <= 2'h2;
      acc(7'h4A, 3'h0, 0, 16'h0000, 0, rd, nak);
      `CHK("moved address", 1'h0, nak)
      acc(ADDR, 3'h0, 0, 16'h0000, 0, rd, nak);
      `CHK("old address", 1'h1, nak)
      cyc(1);
      strap <= 2'h1;
      // Comparator mode above the high limit
      set(13'h0310);
      conv();
      pins(1'h0, 1'h1);
      conv();
      pins(1'h0, 1'h1);
      rw(3'h0, 0, 16'h0000, 2, 16'h1882, "temp high");
      cyc(20);
      pins(1'h1, 1'h1);
      rw(3'h0, 0, 16'h0000, 2, 16'h1882, "temp again");
      conv();
      pins(1'h0, 1'h1);
      // Read mid-conversion must push the next end out
      cyc(900);
      rw(3'h0, 0, 16'h0000, 2, 16'h1882, "temp");
      cyc(1500);
      pins(1'h1, 1'h1);
      cyc(600);
      pins(1'h0, 1'h1);
      set(13'h02F0);
      conv();
      pins(1'h0, 1'h1);
      set(13'h02D0);
      conv();
      pins(1'h1, 1'h1);
      // Critical limit and its hysteresis
      set(13'h05A0);
      conv();
      pins(1'h0, 1'h0);
      rw(3'h0, 0, 16'h0000, 2, 16'h2D06, "temp crit");
      cyc(20);
      pins(1'h1, 1'h0);
      set(13'h04F0);
      conv();
      pins(1'h0, 1'h0);
      set(13'h04D0);
      conv();
      pins(1'h0, 1'h1);
      // Low limit and its hysteresis
      set(13'h0090);
      conv();
      pins(1'h0, 1'h1);
      set(13'h00B0);
      conv();
      pins(1'h0, 1'h1);
      set(13'h00D0);
      conv();
      pins(1'h1, 1'h1);
      // Reads faster than a conversion hold the old value
      for (int i = 0; i < 4; i++) begin
         rw(3'h0, 0, 16'h0000, 2, 16'h0680, "stale temp");
         set(13'h00E0);
         cyc(1500);
      end
      // Event mode
      rw(3'h1, 1, 16'h0002, 1, 16'h0002, "config event");
      conv();
      set(13'h0090);
      conv();
      pins(1'h0, 1'h1);
      conv();
      pins(1'h0, 1'h1);
      rw(3'h0, 0, 16'h0000, 2, 16'h0481, "temp low");
      cyc(20);
      pins(1'h1, 1'h1);
      conv();
      pins(1'h1, 1'h1);
      set(13'h00D0);
      conv();
      pins(1'h0, 1'h1);
      // Both alarms active high
      rw(3'h1, 1, 16'h000E, 1, 16'h000E, "config polarity");
      cyc(20);
      pins(1'h0, 1'h0);
      set(13'h05A0);
      conv();
      pins(1'h1, 1'h1);
      // Fault queue: four trips in a row before the flag
      rw(3'h1, 1, 16'h0010, 1, 16'h0010, "config queue");
      set(13'h0190);
      conv();
      pins(1'h1, 1'h1);
      set(13'h0310);
      cyc(6000);
      pins(1'h1, 1'h1);
      cyc(2000);
      pins(1'h0, 1'h1);
      results();
   end
endmodule : testbench

`default_nettype wire
